// >>> core/borrow_subtractor.sv
`timescale 1ns/10ps
`default_nettype none
module borrow_subtractor
   import rsd_pkg::*;
(
   input wire logic [rsd_pkg::DATA_W-1:0] minuend,
   input wire logic [rsd_pkg::DATA_W-1:0] subtrahend,
   input wire logic carry_in,
   input wire logic chained_nil_in,
   output logic [rsd_pkg::DATA_W-1:0] difference,
   output logic [rsd_pkg::STATUS_W-1:0] status_out
);

   // ------------------------------------------------------------
   // Difference with the inverted carry as borrow
   // ------------------------------------------------------------
   wire logic borrow_in;
   wire logic [DATA_W:0] wide_diff;
   wire logic [4:0] low_diff;
   wire logic zero_result;
   wire logic overflow;

   assign borrow_in = ~carry_in;
   assign wide_diff = {1'b0, minuend} - {1'b0, subtrahend} - {{DATA_W{1'b0}}, borrow_in};
   assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
   assign difference = wide_diff[DATA_W-1:0];
   assign zero_result = (difference == {DATA_W{1'b0}});
   assign overflow = (minuend[DATA_W-1] ^ subtrahend[DATA_W-1])
      & (minuend[DATA_W-1] ^ difference[DATA_W-1]);

   // ------------------------------------------------------------
   // Six affected status bits
   // ------------------------------------------------------------
   // Carry and half-nibble are clear on a borrow, set when none occurred.
   assign status_out[CARRY_POS] = ~wide_diff[DATA_W];
   assign status_out[HALF_NIBBLE_POS] = ~low_diff[4];
   assign status_out[ZERO_POS] = zero_result;
   assign status_out[SIGNED_RANGE_POS] = overflow;
   assign status_out[SIGNED_RESULT_POS] = overflow ^ difference[DATA_W-1];
   assign status_out[CHAINED_NIL_POS] = zero_result & chained_nil_in;

endmodule // borrow_subtractor
`default_nettype wire

// >>> core/rotate_subtract_skip_unit.sv
// What this block does
// - Rotate right via carry into working register.
// - That rotate loads carry from operand bit zero.
// - Subtract: working minus operand minus inverted carry.
// - Memory variant writes difference to memory.
// - Carry clear on negative, set otherwise.
// - Subtracts update six status flags.
// - Decrement memory, skip next when zero.
// - Skip adds dummy slot; three cycles total.
// - Decrement into working register, skip when zero.
// - Fill byte with ones, flags untouched.
// - Set one selected bit, others kept.
`timescale 1ns/10ps
`default_nettype none
module rotate_subtract_skip_unit
   import rsd_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic op_valid,
   input wire rsd_pkg::op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [rsd_pkg::BIT_SEL_W-1:0] op_bit,
   output logic op_ready,
   output logic op_done,
   output logic skip_slot,
   output logic mem_rd_en,
   output logic [ADDR_W-1:0] mem_raddr,
   input wire logic [rsd_pkg::DATA_W-1:0] mem_rdata,
   output logic mem_wr_en,
   output logic [ADDR_W-1:0] mem_waddr,
   output logic [rsd_pkg::DATA_W-1:0] mem_wdata,
   input wire logic working_load,
   input wire logic [rsd_pkg::DATA_W-1:0] working_load_data,
   input wire logic status_load,
   input wire logic [rsd_pkg::STATUS_W-1:0] status_load_data,
   output logic [rsd_pkg::DATA_W-1:0] working_register,
   output logic [rsd_pkg::STATUS_W-1:0] status_flags
);

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      idle_st,
      read_st,
      exec_st,
      dummy_st
   } state_t;

   state_t state_reg;
   state_t state_next;

   op_t op_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [BIT_SEL_W-1:0] bit_reg;
   logic [DATA_W-1:0] working_reg;
   logic [DATA_W-1:0] working_next;
   logic [STATUS_W-1:0] status_reg;
   logic [STATUS_W-1:0] status_next;
   logic wr_en_reg;
   logic wr_en_next;
   logic [ADDR_W-1:0] waddr_reg;
   logic [ADDR_W-1:0] waddr_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic done_reg;
   logic fwd_hit_reg;
   logic [DATA_W-1:0] fwd_data_reg;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   // Returns the one-hot mask that selects a single bit of a byte.
   function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_SEL_W-1:0] sel);
      logic [DATA_W-1:0] mask;
      mask = {{(DATA_W-1){1'b0}}, 1'b1} << sel;
      return mask;
   endfunction

   wire logic accept;
   wire logic in_exec;
   wire logic is_rotate;
   wire logic is_sub_acc;
   wire logic is_sub_mem;
   wire logic is_dec_mem;
   wire logic is_dec_acc;
   wire logic is_fill;
   wire logic is_set_bit;
   wire logic is_subtract;
   wire logic is_decrement;

   assign accept = op_valid & op_ready;
   assign in_exec = (state_reg == exec_st);
   assign is_rotate = (op_reg == rotate_right_borrowflag_to_acc_op);
   assign is_sub_acc = (op_reg == subtract_with_borrow_op);
   assign is_sub_mem = (op_reg == subtract_with_borrow_to_mem_op);
   assign is_dec_mem = (op_reg == decrement_skip_zero_op);
   assign is_dec_acc = (op_reg == decrement_skip_zero_to_acc_op);
   assign is_fill = (op_reg == fill_ones_op);
   assign is_set_bit = (op_reg == set_bit_op);
   assign is_subtract = is_sub_acc | is_sub_mem;
   assign is_decrement = is_dec_mem | is_dec_acc;

   // ------------------------------------------------------------
   // Operand fetch with write bypass
   // ------------------------------------------------------------
   // A write issued in the previous operation lands in the cycle before
   // this read, so wr_en_reg is low here and the pending data is never taken.
   wire logic fwd_hit_next;
   wire logic [DATA_W-1:0] operand;

   assign fwd_hit_next = wr_en_reg & (waddr_reg == addr_reg);
   assign operand = fwd_hit_reg ? fwd_data_reg : mem_rdata;

   // ------------------------------------------------------------
   // Results of each operation
   // ------------------------------------------------------------
   wire logic [DATA_W-1:0] rotate_result;
   wire logic [DATA_W-1:0] sub_result;
   wire logic [STATUS_W-1:0] sub_status;
   wire logic [DATA_W-1:0] dec_result;
   wire logic dec_zero;
   wire logic [DATA_W-1:0] set_bit_result;
   wire logic [STATUS_W-1:0] rotate_status;
   wire logic take_skip;

   assign rotate_result = {status_reg[CARRY_POS], operand[DATA_W-1:1]};

   // Only the carry position changes; every other status bit is copied.
   assign rotate_status = (status_reg & ~(STATUS_W'(1) << CARRY_POS))
      | (STATUS_W'(operand[0]) << CARRY_POS);

   borrow_subtractor u_subtractor (
      .minuend(working_reg),
      .subtrahend(operand),
      .carry_in(status_reg[CARRY_POS]),
      .chained_nil_in(status_reg[CHAINED_NIL_POS]),
      .difference(sub_result),
      .status_out(sub_status)
   );

   assign dec_result = operand - DECREMENT_STEP;
   assign dec_zero = (dec_result == {DATA_W{1'b0}});
   assign set_bit_result = operand | bit_mask(bit_reg);
   assign take_skip = in_exec & is_decrement & dec_zero;

   // ------------------------------------------------------------
   // Working register and status next values
   // ------------------------------------------------------------
   always_comb begin
      working_next = working_reg;
      if (in_exec) begin
         if (is_rotate) begin
            working_next = rotate_result;
         end else if (is_sub_acc) begin
            working_next = sub_result;
         end else if (is_dec_acc) begin
            working_next = dec_result;
         end
      end else if (working_load && (state_reg == idle_st)) begin
         working_next = working_load_data;
      end
   end

   // Decrement, fill and set-bit leave the status word as it is.
   always_comb begin
      status_next = status_reg;
      if (in_exec) begin
         if (is_rotate) begin
            status_next = rotate_status;
         end else if (is_subtract) begin
            status_next = sub_status;
         end
      end else if (status_load && (state_reg == idle_st)) begin
         status_next = status_load_data;
      end
   end

   // ------------------------------------------------------------
   // Memory write-back
   // ------------------------------------------------------------
   // The rotate and the accumulator-directed decrement never write memory.
   always_comb begin
      wr_en_next = 1'b0;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      if (in_exec) begin
         waddr_next = addr_reg;
         if (is_sub_mem) begin
            wr_en_next = 1'b1;
            wdata_next = sub_result;
         end else if (is_dec_mem) begin
            wr_en_next = 1'b1;
            wdata_next = dec_result;
         end else if (is_fill) begin
            wr_en_next = 1'b1;
            wdata_next = FILL_ONES_VALUE;
         end else if (is_set_bit) begin
            wr_en_next = 1'b1;
            wdata_next = set_bit_result;
         end
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // A plain operation holds two slots; a taken skip appends a third.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         idle_st: begin
            if (accept) begin
               state_next = read_st;
            end
         end
         read_st: begin
            state_next = exec_st;
         end
         exec_st: begin
            if (take_skip) begin
               state_next = dummy_st;
            end else begin
               state_next = idle_st;
            end
         end
         dummy_st: begin
            state_next = idle_st;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg <= idle_st;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         op_reg <= rotate_right_borrowflag_to_acc_op;
         addr_reg <= '0;
         bit_reg <= '0;
      end else if (accept) begin
         op_reg <= op_code;
         addr_reg <= op_addr;
         bit_reg <= op_bit;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         fwd_hit_reg <= 1'b0;
         fwd_data_reg <= '0;
      end else if (state_reg == read_st) begin
         fwd_hit_reg <= fwd_hit_next;
         fwd_data_reg <= wdata_reg;
      end
   end

   // ------------------------------------------------------------
   // Architectural state
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         working_reg <= WORKING_RESET;
         status_reg <= STATUS_RESET;
      end else begin
         working_reg <= working_next;
         status_reg <= status_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         wr_en_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         done_reg <= 1'b0;
      end else begin
         wr_en_reg <= wr_en_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         done_reg <= in_exec & ~take_skip;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // The dummy slot tells the decoder to run the fetched word as a nop.
   assign skip_slot = (state_reg == dummy_st);
   assign op_ready = (state_reg == idle_st);
   assign op_done = done_reg | skip_slot;
   assign mem_rd_en = (state_reg == read_st);
   assign mem_raddr = addr_reg;
   assign mem_wr_en = wr_en_reg;
   assign mem_waddr = waddr_reg;
   assign mem_wdata = wdata_reg;
   assign working_register = working_reg;
   assign status_flags = status_reg;

endmodule // rotate_subtract_skip_unit
`default_nettype wire

// >>> core/rsd_pkg.sv
package rsd_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int STATUS_W = 6;
   localparam int BIT_SEL_W = 3;

   // ------------------------------------------------------------
   // Status word layout
   // ------------------------------------------------------------
   localparam int CARRY_POS = 0;
   localparam int HALF_NIBBLE_POS = 1;
   localparam int ZERO_POS = 2;
   localparam int SIGNED_RANGE_POS = 3;
   localparam int SIGNED_RESULT_POS = 4;
   localparam int CHAINED_NIL_POS = 5;

   // ------------------------------------------------------------
   // Reset and fixed values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;
   localparam logic [STATUS_W-1:0] STATUS_RESET = 6'h00;
   localparam logic [DATA_W-1:0] FILL_ONES_VALUE = 8'hFF;
   localparam logic [DATA_W-1:0] DECREMENT_STEP = 8'h01;

   // ------------------------------------------------------------
   // Operations
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      rotate_right_borrowflag_to_acc_op,
      subtract_with_borrow_op,
      subtract_with_borrow_to_mem_op,
      decrement_skip_zero_op,
      decrement_skip_zero_to_acc_op,
      fill_ones_op,
      set_bit_op
   } op_t;

endpackage

// >>> tb/rotate_subtract_skip_unit_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rotate_subtract_skip_unit_chk
   import rsd_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic op_valid,
   input wire rsd_pkg::op_t op_code,
   input wire logic [ADDR_W-1:0] op_addr,
   input wire logic [2:0] op_bit,
   input wire logic op_ready,
   input wire logic op_done,
   input wire logic skip_slot,
   input wire logic mem_rd_en,
   input wire logic [ADDR_W-1:0] mem_raddr,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_wr_en,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] working_register,
   input wire logic [5:0] status_flags
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   wire go = op_valid && op_ready;
   wire sub = op_code == subtract_with_borrow_op || op_code == subtract_with_borrow_to_mem_op;
   property p_read;
      go |=> mem_rd_en && mem_raddr == $past(op_addr);
   endproperty
   a_read: assert property (p_read) else $error("read strobe missing");
   property p_busy;
      go |=> !op_ready [*2] ##1 op_done;
   endproperty
   a_busy: assert property (p_busy) else $error("operation timing wrong");
   property p_skip;
      skip_slot |-> op_done && !op_ready ##1 op_ready;
   endproperty
   a_skip: assert property (p_skip) else $error("skip slot timing wrong");
   property p_rot;
      go && op_code == rotate_right_borrowflag_to_acc_op |-> ##3 !mem_wr_en &&
         working_register == {$past(status_flags[0], 2), $past(mem_rdata[7:1])};
   endproperty
   a_rot: assert property (p_rot) else $error("rotate result wrong");
   property p_rotc;
      go && op_code == rotate_right_borrowflag_to_acc_op |->
         ##3 status_flags == {$past(status_flags[5:1], 2), $past(mem_rdata[0])};
   endproperty
   a_rotc: assert property (p_rotc) else $error("rotate flags wrong");
   property p_borrow;
      go && sub |-> ##3 status_flags[0] == ({1'b0, $past(working_register, 2)} >=
         {1'b0, $past(mem_rdata)} + !$past(status_flags[0], 2));
   endproperty
   a_borrow: assert property (p_borrow) else $error("borrow flag wrong");
   property p_dec;
      go && op_code == decrement_skip_zero_op |-> ##3 mem_wr_en &&
         mem_wdata == $past(mem_rdata) - 8'h01 && skip_slot == (mem_wdata == 8'h00) &&
         $stable(status_flags);
   endproperty
   a_dec: assert property (p_dec) else $error("decrement result wrong");
   property p_deca;
      go && op_code == decrement_skip_zero_to_acc_op |->
         ##3 !mem_wr_en && $stable(status_flags) &&
         working_register == $past(mem_rdata) - 8'h01 &&
         skip_slot == (working_register == 8'h00);
   endproperty
   a_deca: assert property (p_deca) else $error("decrement to register wrong");
   property p_fill;
      go && op_code == fill_ones_op |-> ##3 mem_wr_en && mem_wdata == 8'hFF && $stable(status_flags);
   endproperty
   a_fill: assert property (p_fill) else $error("fill result wrong");
   property p_bit;
      go && op_code == set_bit_op |->
         ##3 mem_wr_en && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(op_bit, 3)));
   endproperty
   a_bit: assert property (p_bit) else $error("set bit result wrong");
endmodule // rotate_subtract_skip_unit_chk
bind rotate_subtract_skip_unit rotate_subtract_skip_unit_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk,
   .resetn, .op_valid, .op_code, .op_addr, .op_bit, .op_ready, .op_done, .skip_slot, .mem_rd_en,
   .mem_raddr, .mem_rdata, .mem_wr_en, .mem_wdata, .working_register, .status_flags);
`default_nettype wire

// >>> tb/rotate_subtract_skip_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rotate_subtract_skip_unit_tb_top;
   import rsd_pkg::*;
   logic mclk = 0, resetn = 0, op_valid = 0, working_load = 0, status_load = 0;
   op_t op_code = fill_ones_op;
   logic [7:0] op_addr = 8'h00, working_load_data = 8'h00, mem_raddr, mem_waddr, mem_wdata;
   logic [2:0] op_bit = 3'h0;
   logic [5:0] status_load_data = 6'h00, status_flags;
   logic op_ready, op_done, skip_slot, mem_rd_en, mem_wr_en;
   logic [7:0] mem_rdata, working_register;
   int errors = 0, check_count = 0, seed = 32'hc789, md[256], wk = 0, st = 0;
   always #5 mclk = ~mclk;
   rotate_subtract_skip_unit u_dut (.mclk, .resetn, .op_valid, .op_code, .op_addr, .op_bit,
      .op_ready, .op_done, .skip_slot, .mem_rd_en, .mem_raddr, .mem_rdata, .mem_wr_en,
      .mem_waddr, .mem_wdata, .working_load, .working_load_data, .status_load,
      .status_load_data, .working_register, .status_flags);
   rss_mem u_mem (.mclk, .rd_en(mem_rd_en), .raddr(mem_raddr), .wr_en(mem_wr_en),
      .waddr(mem_waddr), .wdata(mem_wdata), .rdata(mem_rdata));
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // One operation against the reference model
   // ----------------------------------------
   task automatic run(op_t o, logic [7:0] a, logic [2:0] b);
      int m, c, w, sk, d, z, vf;
      logic rdy;
      m = md[a];
      c = st & 1;
      w = -1;
      sk = 0;
      op_code = o;
      op_addr = a;
      op_bit = b;
      op_valid = 1;
      do begin
         rdy = op_ready;
         @(negedge mclk);
      end while (rdy !== 1'b1);
      op_valid = 0;
      case (o)
         rotate_right_borrowflag_to_acc_op: begin
            wk = (c << 7) | (m >> 1);
            st = (st & 62) | (m & 1);
         end
         subtract_with_borrow_op, subtract_with_borrow_to_mem_op: begin
            d = wk - m - (1 - c);
            z = (d & 255) == 0;
            vf = ((wk ^ m) & (wk ^ d) & 128) != 0;
            st = (d >= 0) | (((wk & 15) - (m & 15) - (1 - c) >= 0) << 1) | (z << 2) | (vf << 3)
               | ((vf ^ ((d >> 7) & 1)) << 4) | ((z & (st >> 5)) << 5);
            if (o == subtract_with_borrow_op) wk = d & 255;
            else w = d & 255;
         end
         decrement_skip_zero_op: begin
            w = (m + 255) & 255;
            sk = w == 0;
         end
         decrement_skip_zero_to_acc_op: begin
            wk = (m + 255) & 255;
            sk = wk == 0;
         end
         fill_ones_op: w = 255;
         set_bit_op: w = m | (1 << b);
         default: ;
      endcase
      for (int i = 0; i < 8 && op_done !== 1'b1; i++) @(negedge mclk);
      chk("done", op_done, 8'h01);
      chk("skip", skip_slot, sk[7:0]);
      chk("wr_en", mem_wr_en, {7'h00, w >= 0});
      chk("working", working_register, wk[7:0]);
      chk("status", status_flags, st[5:0]);
      if (w >= 0) begin
         chk("wdata", mem_wdata, w[7:0]);
         chk("waddr", mem_waddr, a);
         md[a] = w;
      end
   endtask
   initial begin
      for (int i = 0; i < 256; i++) md[i] = $random(seed) & 255;
      md[3] = 1;
      md[4] = 1;
      for (int i = 0; i < 256; i++) u_mem.mem[i] = md[i][7:0];
      repeat (5) @(negedge mclk);
      resetn = 1;
      chk("reset working", working_register, 8'h00);
      for (int k = 0; k < 8; k++) run(op_t'(k), 8'(k), 3'(k));
      $display("test of every code done");
      for (int k = 0; k < 300; k++) begin
         if (($random(seed) & 3) == 0) begin
            while (op_ready !== 1'b1) @(negedge mclk);
            working_load = 1;
            status_load = 1;
            working_load_data = 8'($random(seed));
            status_load_data = 6'($random(seed));
            wk = working_load_data;
            st = status_load_data;
            @(negedge mclk);
            working_load = 0;
            status_load = 0;
         end
         run(op_t'($random(seed) & 7), 8'($random(seed) & 7), 3'($random(seed)));
      end
      $display("test of random back to back operations done");
      op_code = fill_ones_op;
      op_valid = 1;
      repeat (2) @(negedge mclk);
      resetn = 0;
      op_valid = 0;
      repeat (2) @(negedge mclk);
      resetn = 1;
      wk = 0;
      st = 0;
      chk("reset status", status_flags, 8'h00);
      for (int k = 0; k < 8; k++) run(op_t'(k), 8'h05, 3'(7 - k));
      $display("test of reset in mid operation done");
      wrap_up();
   end
   initial begin
      #100000;
      errors++;
      wrap_up();
   end
endmodule // rotate_subtract_skip_unit_tb_top
`default_nettype wire

// >>> tb/rss_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Registered data memory
// ----------------------------------------
// Read data follows a read strobe by one cycle; otherwise the bus toggles.
module rss_mem #(
   parameter int ADDR_W = 8
) (
   input wire logic mclk,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] raddr,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [2**ADDR_W];
   initial rdata = 8'hA5;
   always @(posedge mclk) begin
      if (wr_en) mem[waddr] <= wdata;
      rdata <= rd_en ? mem[raddr] : ~rdata;
   end
endmodule // rss_mem
`default_nettype wire
